// >>> shared/rsg_regs.svh
`ifndef RSG_REGS_SVH
`define RSG_REGS_SVH
// address space and clock-register window
`define RSG_ADDR_W 19
`define RSG_DATA_W 8
`define RSG_REG_COUNT 16
`define RSG_REG_IDX_W 4
`define RSG_REG_BASE 19'h7FFF0
// power-on settling interval in microseconds
`define RSG_SETTLE_US 200
`define RSG_CLK_MHZ 10
// reference tick: 32.768 kHz seen on a 10 MHz clock
`define RSG_REF_HZ 32768
`define RSG_CLK_HZ 10000000
// index of the alarm/frequency-test control register
`define RSG_CTRL_IDX 4'hE
`define RSG_CTRL_FT_BIT 6
`define RSG_CTRL_ALARM_BIT 7
`define RSG_BYTE_ZERO 8'h00
`endif

// >>> shared/rsg_pkg.sv
package rsg_pkg;
  `include "rsg_regs.svh"

  typedef enum logic [1:0] {
    RSG_ST_SETTLE = 2'b00,
    RSG_ST_RUN = 2'b01,
    RSG_ST_FAIL = 2'b11
  } rsg_state_e;

  // host strobes, all active low
  typedef struct packed {
    logic cs_n;
    logic oe_n;
    logic we_n;
  } rsg_strobe_s;

  // sram-facing gate outputs
  typedef struct packed {
    logic sel_n;
    logic rd_n;
  } rsg_ram_s;
endpackage : rsg_pkg

// >>> rtl/rsg_reg_mem.sv
`timescale 1ns/1ps
`include "rsg_regs.svh"
module rsg_reg_mem #(
  parameter int DEPTH = `RSG_REG_COUNT,
  parameter int AW = `RSG_REG_IDX_W,
  parameter int DW = `RSG_DATA_W
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_idx,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_idx,
  output logic [DW-1:0] rd_data,
  output logic [DW-1:0] ctrl_byte
);
  logic [DW-1:0] mem_q [DEPTH];
  logic [DW-1:0] mem_d [DEPTH];
  logic [DW-1:0] rd_q;
  logic [DW-1:0] rd_d;

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_ent
      always_comb begin
        mem_d[gi] = mem_q[gi];
        if (wr_en && (wr_idx == AW'(gi))) begin
          mem_d[gi] = wr_data;
        end
      end
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          mem_q[gi] <= '0;
        end else begin
          mem_q[gi] <= mem_d[gi];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // registered read
  // ------------------------------------------------------------
  always_comb begin
    rd_d = mem_q[rd_idx];
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rd_q <= '0;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign rd_data = rd_q;
  assign ctrl_byte = mem_q[`RSG_CTRL_IDX];
endmodule : rsg_reg_mem

// >>> rtl/rsg_bus_gate.sv
`timescale 1ns/1ps
`include "rsg_regs.svh"
module rsg_bus_gate #(
  parameter int SETTLE_US = `RSG_SETTLE_US
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [`RSG_ADDR_W-1:0] addr_lines,
  input wire rsg_pkg::rsg_strobe_s host_strobe,
  input wire logic [`RSG_DATA_W-1:0] byte_lines_in,
  output logic [`RSG_DATA_W-1:0] byte_lines_out,
  output logic byte_lines_oe,
  output rsg_pkg::rsg_ram_s ram_gate,
  input wire logic supply_low,
  input wire logic osc_in,
  output logic alarm_or_freq_test_n_out,
  output logic alarm_or_freq_test_n_oe,
  output logic reset_out_n_out,
  output logic reset_out_n_oe,
  output logic [31:0] tick_count
);
  import rsg_pkg::*;

  localparam int SETTLE_CYC = SETTLE_US * `RSG_CLK_MHZ;
  localparam int CW = $clog2(SETTLE_CYC + 1);

  logic hit;
  logic access_ok;
  logic [`RSG_REG_IDX_W-1:0] reg_idx;
  logic [`RSG_DATA_W-1:0] rd_data;
  logic [`RSG_DATA_W-1:0] ctrl_byte;
  logic wr_req;
  rsg_state_e state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic we_act_q, we_act_d;
  logic osc_s1_q, osc_s2_q, osc_s3_q;
  logic [31:0] tick_q, tick_d;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  // top window compare
  always_comb begin
    hit = (addr_lines >= `RSG_REG_BASE);
    reg_idx = addr_lines[`RSG_REG_IDX_W-1:0];
  end

  always_comb begin
    access_ok = (state_q == RSG_ST_RUN) && !supply_low;
  end

  // ------------------------------------------------------------
  // sram gate
  // ------------------------------------------------------------
  always_comb begin
    ram_gate.sel_n = host_strobe.cs_n;
    ram_gate.rd_n = host_strobe.oe_n;
    if (hit || !access_ok) begin
      ram_gate.sel_n = 1'b1;
      ram_gate.rd_n = 1'b1;
    end
  end

  always_comb begin
    byte_lines_oe = hit && access_ok && !host_strobe.cs_n && !host_strobe.oe_n
                    && host_strobe.we_n;
    byte_lines_out = byte_lines_oe ? rd_data : `RSG_BYTE_ZERO;
  end

  // ------------------------------------------------------------
  // register write
  // ------------------------------------------------------------
  // write starts at later strobe
  always_comb begin
    we_act_d = !host_strobe.cs_n && !host_strobe.we_n && hit && access_ok;
    wr_req = we_act_d && !we_act_q;
  end

  rsg_reg_mem u_mem (
    .clock(clock),
    .rstn(rstn),
    .wr_en(wr_req),
    .wr_idx(reg_idx),
    .wr_data(byte_lines_in),
    .rd_idx(reg_idx),
    .rd_data(rd_data),
    .ctrl_byte(ctrl_byte)
  );

  // ------------------------------------------------------------
  // power-on reset sequence
  // ------------------------------------------------------------
  // settling interval
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      RSG_ST_SETTLE: begin
        if (cnt_q == CW'(SETTLE_CYC - 1)) begin
          state_d = RSG_ST_RUN;
        end else begin
          cnt_d = cnt_q + CW'(1);
        end
      end
      RSG_ST_RUN: begin
        if (supply_low) begin
          state_d = RSG_ST_FAIL;
        end
      end
      RSG_ST_FAIL: begin
        if (!supply_low) begin
          state_d = RSG_ST_SETTLE;
          cnt_d = '0;
        end
      end
      default: begin
        state_d = RSG_ST_SETTLE;
        cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= RSG_ST_SETTLE;
      cnt_q <= '0;
      we_act_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      we_act_q <= we_act_d;
    end
  end

  always_comb begin
    reset_out_n_out = 1'b0;
    reset_out_n_oe = (state_q != RSG_ST_RUN);
  end

  // ------------------------------------------------------------
  // timekeeping reference
  // ------------------------------------------------------------
  // count rising reference edges always
  always_comb begin
    tick_d = tick_q;
    if (osc_s2_q && !osc_s3_q) begin
      tick_d = tick_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
      tick_q <= '0;
    end else begin
      osc_s1_q <= osc_in;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      tick_q <= tick_d;
    end
  end

  assign tick_count = tick_q;

  always_comb begin
    alarm_or_freq_test_n_out = 1'b0;
    if (ctrl_byte[`RSG_CTRL_FT_BIT]) begin
      alarm_or_freq_test_n_oe = !osc_s2_q;
    end else begin
      alarm_or_freq_test_n_oe = ctrl_byte[`RSG_CTRL_ALARM_BIT];
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  chk_ram_pass: assert property (!hit && access_ok |->
    ram_gate.sel_n == host_strobe.cs_n && ram_gate.rd_n == host_strobe.oe_n)
    else $error("sram strobes not passed through");
  chk_ram_block: assert property (hit |-> ram_gate.sel_n)
    else $error("sram selected on clock address");
  chk_read_drive: assert property (hit && access_ok && !host_strobe.cs_n &&
    !host_strobe.oe_n && host_strobe.we_n |-> byte_lines_oe)
    else $error("register read not driven");
  chk_read_quiet: assert property (!hit || !access_ok |-> !byte_lines_oe)
    else $error("byte lines driven outside clock window");
  chk_od_level: assert property (alarm_or_freq_test_n_out == 1'b0)
    else $error("open drain drives high");
  chk_settle_len: assert property ($rose(state_q == RSG_ST_RUN) |->
    $past(cnt_q) == CW'(SETTLE_CYC - 1))
    else $error("settling interval wrong");
  chk_reset_block: assert property (reset_out_n_oe |->
    ram_gate.sel_n && !byte_lines_oe && !wr_req)
    else $error("access while reset asserted");
  chk_low_block: assert property (supply_low |-> ram_gate.sel_n && !wr_req)
    else $error("access while supply low");
  chk_tick_run: assert property (osc_s2_q && !osc_s3_q |=>
    tick_q == $past(tick_q) + 32'h0000_0001)
    else $error("reference edge not counted");
  chk_write_once: assert property (wr_req |=> !wr_req)
    else $error("write pulse too long");
endmodule : rsg_bus_gate

// >>> sim/rsg_sram_model.sv
`timescale 1ns/1ps
`include "rsg_regs.svh"
module rsg_sram_model (
  input wire rsg_pkg::rsg_ram_s ram_gate,
  input wire logic [`RSG_ADDR_W-1:0] addr_lines,
  output logic [`RSG_DATA_W-1:0] ram_data,
  output logic ram_oe
);
  import rsg_pkg::*;
  logic [7:0] last_q = 8'h00;
  // ----
  // read drive, inverse of last byte when released
  // ----
  assign ram_oe = ~ram_gate.sel_n & ~ram_gate.rd_n;
  assign ram_data = ram_oe ? (addr_lines[7:0] ^ 8'h3C) : ~last_q;
  always @(ram_data) begin
    if (ram_oe) begin
      last_q = ram_data;
    end
  end
endmodule : rsg_sram_model

// >>> sim/rsg_bus_gate_tb.sv
`timescale 1ns/1ps
`include "rsg_regs.svh"
module rsg_bus_gate_tb;
  import rsg_pkg::*;
  typedef struct packed {logic [18:0] a; logic [2:0] s; logic [2:0] e;} rsg_row_s;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [18:0] addr = 19'h00000;
  rsg_strobe_s stb = 3'b111;
  logic [7:0] host_d = 8'h00;
  logic supply_low = 1'b0;
  logic osc_in = 1'b0;
  logic [7:0] bl_out, ram_d, bus;
  logic bl_oe, ram_oe, al_out, al_oe, rs_out, rs_oe;
  rsg_ram_s ram_gate;
  logic [31:0] ticks, t0;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  // rows: address, {cs_n,oe_n,we_n}, expected {sel_n,rd_n,byte_oe}
  rsg_row_s rows [6] = '{'{19'h00000, 3'b001, 3'b000}, '{19'h7FFEF, 3'b011, 3'b010},
    '{19'h7FFF0, 3'b001, 3'b111}, '{19'h7FFFF, 3'b101, 3'b110},
    '{19'h3FFF0, 3'b101, 3'b100}, '{19'h7FFF8, 3'b011, 3'b110}};
  // ----
  // wiring
  // ----
  assign bus = bl_oe ? bl_out : (ram_oe ? ram_d : host_d);
  rsg_bus_gate #(.SETTLE_US(1)) u_rsg_bus_gate (.clock(clock), .rstn(rstn),
    .addr_lines(addr), .host_strobe(stb), .byte_lines_in(bus), .byte_lines_out(bl_out),
    .byte_lines_oe(bl_oe), .ram_gate(ram_gate), .supply_low(supply_low), .osc_in(osc_in),
    .alarm_or_freq_test_n_out(al_out), .alarm_or_freq_test_n_oe(al_oe),
    .reset_out_n_out(rs_out), .reset_out_n_oe(rs_oe), .tick_count(ticks));
  rsg_sram_model u_rsg_sram_model (.ram_gate(ram_gate), .addr_lines(addr),
    .ram_data(ram_d), .ram_oe(ram_oe));
  always #50 clock = ~clock;
  always #15259 osc_in = ~osc_in;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_of_test();
    end
  end
  // ----
  // tasks
  // ----
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic drive(input logic [18:0] a, input logic [2:0] s, input logic [7:0] d);
    @(negedge clock);
    addr = a;
    stb = s;
    host_d = d;
    #10;
  endtask : drive
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  // ----
  // sequence
  // ----
  initial begin
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    drive(19'h00010, 3'b001, 8'h00);
    chk("sel_settle", {7'h00, ram_gate.sel_n}, 8'h01);
    chk("rst_settle", {7'h00, rs_oe ? rs_out : 1'b1}, 8'h00);
    drive(19'h00010, 3'b111, 8'h00);
    repeat (12) @(negedge clock);
    chk("rst_done", {7'h00, rs_oe ? rs_out : 1'b1}, 8'h01);
    foreach (rows[i]) begin
      drive(rows[i].a, rows[i].s, 8'h00);
      chk("gate", {5'h00, ram_gate, bl_oe}, {5'h00, rows[i].e});
      drive(rows[i].a, 3'b111, 8'h00);
    end
    // write, strobes released, then read back
    drive(19'h7FFF3, 3'b010, 8'hA5);
    drive(19'h7FFF3, 3'b111, 8'hA5);
    drive(19'h7FFF3, 3'b001, 8'h00);
    @(negedge clock);
    chk("rd_byte", bus, 8'hA5);
    drive(19'h7FFF3, 3'b111, 8'h00);
    for (int v = 1; v >= 0; v--) begin
      drive(19'h7FFFE, 3'b010, {v[0], 7'h00});
      drive(19'h7FFFE, 3'b111, 8'h00);
      @(negedge clock);
      chk("alarm_pin", {7'h00, al_oe ? al_out : 1'b1}, {7'h00, ~v[0]});
    end
    drive(19'h7FFFE, 3'b010, 8'h40);
    drive(19'h7FFFE, 3'b111, 8'h00);
    @(posedge osc_in);
    repeat (4) @(negedge clock);
    chk("ft_high", {7'h00, al_oe ? al_out : 1'b1}, 8'h01);
    @(negedge osc_in);
    repeat (4) @(negedge clock);
    chk("ft_low", {7'h00, al_oe ? al_out : 1'b1}, 8'h00);
    t0 = ticks;
    @(negedge clock);
    supply_low = 1'b1;
    drive(19'h7FFF3, 3'b001, 8'h00);
    chk("low_rd", {7'h00, bl_oe}, 8'h00);
    drive(19'h00020, 3'b001, 8'h00);
    chk("low_sram", {6'h00, ram_gate}, 8'h03);
    repeat (800) @(negedge clock);
    chk("ticking", {7'h00, ticks > t0 + 1}, 8'h01);
    supply_low = 1'b0;
    drive(19'h00020, 3'b111, 8'h00);
    repeat (14) @(negedge clock);
    drive(19'h7FFF3, 3'b001, 8'h00);
    @(negedge clock);
    chk("rd_after", bus, 8'hA5);
    drive(19'h00012, 3'b001, 8'h00);
    chk("ram_rd", bus, 8'h2E);
    @(negedge clock);
    rstn = 1'b0;
    #10;
    chk("rst_mid", {6'h00, ram_gate}, 8'h03);
    @(negedge clock);
    chk("rst_pin", {7'h00, rs_oe ? rs_out : 1'b1}, 8'h00);
    rstn = 1'b1;
    repeat (14) @(negedge clock);
    chk("rst_again", {7'h00, rs_oe ? rs_out : 1'b1}, 8'h01);
    chk("ram_again", {6'h00, ram_gate}, 8'h00);
    end_of_test();
  end
endmodule : rsg_bus_gate_tb
